// *** core/uirq_pkg.sv ***
// constants shared by both ends of the usb event interrupt prioritizer
`default_nettype none
package uirq_pkg;
    // ***********************************************
    // source positions, priority index 0 is highest
    // ***********************************************
    localparam int UIRQ_NSRC = 32;
    localparam int UIRQ_IDX_W = 5;
    localparam int UIRQ_VEC_W = 8;
    localparam int UIRQ_VEC_SHIFT = 2;
    localparam logic [4:0] UIRQ_IDX_SETUP_DATA = 5'h00;
    localparam logic [4:0] UIRQ_IDX_SOF = 5'h01;
    localparam logic [4:0] UIRQ_IDX_SETUP_TOK = 5'h02;
    // reserved slots at codes 1C, 44, 64, 68, 6C
    localparam logic [31:0] UIRQ_RSVD_MASK = 32'h0E02_0080;
    // high speed entered and the six ping-nak sources
    localparam logic [31:0] UIRQ_HS_ONLY_MASK = 32'h00FC_0020;
    // sources driven by the block itself, not by the event vector
    localparam logic [31:0] UIRQ_INTERNAL_MASK = 32'h0000_0007;
    // ***********************************************
    // processor side
    // ***********************************************
    localparam logic [15:0] UIRQ_AUTOVEC_ADDR = 16'h0045;
    localparam int UIRQ_EXT_IRQ_FLAG_REG_MAIN_BIT = 4;
    localparam int UIRQ_EIE_USB_BIT = 0;
    localparam logic [31:0] UIRQ_IE_RESET = 32'h0000_0000;
    // ***********************************************
    // setup packet and frame number
    // ***********************************************
    localparam int UIRQ_SETUP_BYTES = 8;
    localparam logic [3:0] UIRQ_SETUP_CNT_FULL = 4'h8;
    localparam int UIRQ_FRAME_W = 11;
endpackage : uirq_pkg
`default_nettype wire

// *** core/uirq_if.sv ***
// interface joining the interrupt prioritizer and the processor firmware end
`default_nettype none
interface uirq_if;
    import uirq_pkg::*;
    // firmware to device
    logic [31:0] ie;
    logic clr_we;
    logic [31:0] clr_mask;
    logic main_clr;
    logic eie_usb;
    logic av_en;
    logic [15:0] fetch_addr;
    logic [7:0] fetch_byte;
    // device to firmware
    logic [31:0] irq_latch;
    logic [7:0] vector_byte;
    logic main_flag;
    logic cpu_irq;
    logic [7:0] fetch_data;
    logic [63:0] setup_bytes;
    logic [10:0] frame_number;
    modport dev (
        input ie, clr_we, clr_mask, main_clr, eie_usb, av_en, fetch_addr, fetch_byte,
        output irq_latch, vector_byte, main_flag, cpu_irq, fetch_data,
        output setup_bytes, frame_number
    );
    modport fw (
        output ie, clr_we, clr_mask, main_clr, eie_usb, av_en, fetch_addr, fetch_byte,
        input irq_latch, vector_byte, main_flag, cpu_irq, fetch_data,
        input setup_bytes, frame_number
    );
endinterface : uirq_if
`default_nettype wire

// *** core/uirq_fw_end.sv ***
// processor firmware end: enables, ordered clearing and fetch path
`default_nettype none
module uirq_fw_end
    import uirq_pkg::*;
(
    input wire logic core_clk_in,
    input wire logic rstn_in,
    uirq_if.fw bus_if,
    input wire logic [31:0] user_ie_in,
    input wire logic user_eie_in,
    input wire logic user_av_in,
    input wire logic user_svc_in,
    input wire logic [15:0] user_fetch_addr_in,
    input wire logic [7:0] user_fetch_byte_in,
    output logic user_irq_out,
    output logic user_busy_out,
    output logic [4:0] user_svc_idx_out,
    output logic [63:0] user_setup_out,
    output logic [7:0] user_fetch_data_out
);
    typedef enum logic [1:0] {UIRQ_FW_IDLE, UIRQ_FW_CLR_MAIN, UIRQ_FW_CLR_SRC} uirq_fw_st_t;
    uirq_fw_st_t st_r;
    logic [4:0] idx_r;
    logic main_clr_r;
    logic clr_we_r;
    logic [31:0] clr_mask_r;
    logic [31:0] ie_r;
    logic eie_r;
    logic av_r;
    logic [63:0] setup_r;
    logic [7:0] fetch_r;
    logic irq_r;
    wire svc_start = (st_r == UIRQ_FW_IDLE) && user_svc_in && bus_if.main_flag;
    wire [4:0] cur_idx = bus_if.vector_byte[UIRQ_VEC_SHIFT +: UIRQ_IDX_W];

    // ***********************************************
    // outputs toward the device and the user, fetch address and byte passed through unregistered
    // ***********************************************
    assign bus_if.ie = ie_r;
    assign bus_if.eie_usb = eie_r; // RULE10
    assign bus_if.av_en = av_r; // RULE21
    assign bus_if.main_clr = main_clr_r;
    assign bus_if.clr_we = clr_we_r;
    assign bus_if.clr_mask = clr_mask_r;
    assign bus_if.fetch_addr = user_fetch_addr_in;
    assign bus_if.fetch_byte = user_fetch_byte_in;
    assign user_busy_out = (st_r != UIRQ_FW_IDLE);
    assign user_svc_idx_out = idx_r;
    assign user_setup_out = setup_r;
    assign user_fetch_data_out = fetch_r;
    assign user_irq_out = irq_r;

    // service sequence: main flag first, then the source latch
    always_ff @(posedge core_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            st_r <= UIRQ_FW_IDLE;
            idx_r <= 5'h00;
            main_clr_r <= 1'b0;
            clr_we_r <= 1'b0;
            clr_mask_r <= 32'h0000_0000;
            ie_r <= UIRQ_IE_RESET;
            eie_r <= 1'b0;
            av_r <= 1'b0;
            setup_r <= 64'h0000_0000_0000_0000;
            fetch_r <= 8'h00;
            irq_r <= 1'b0;
        end else begin
            ie_r <= user_ie_in;
            eie_r <= user_eie_in;
            av_r <= user_av_in;
            fetch_r <= bus_if.fetch_data;
            irq_r <= bus_if.cpu_irq;
            main_clr_r <= 1'b0;
            clr_we_r <= 1'b0;
            case (st_r)
                UIRQ_FW_IDLE: begin
                    if (svc_start) begin
                        idx_r <= cur_idx;
                        main_clr_r <= 1'b1; // RULE11 RULE13
                        st_r <= UIRQ_FW_CLR_MAIN;
                    end
                end
                UIRQ_FW_CLR_MAIN: begin
                    clr_we_r <= 1'b1; // RULE1
                    clr_mask_r <= 32'h0000_0001 << idx_r;
                    if (idx_r == UIRQ_IDX_SETUP_DATA) begin
                        setup_r <= bus_if.setup_bytes; // RULE16
                    end
                    st_r <= UIRQ_FW_CLR_SRC;
                end
                UIRQ_FW_CLR_SRC: begin
                    st_r <= UIRQ_FW_IDLE;
                end
                default: begin
                    st_r <= UIRQ_FW_IDLE;
                end
            endcase
        end
    end
endmodule : uirq_fw_end
`default_nettype wire

// *** core/uirq_dev_end.sv ***
// device end: request latches, prioritizer, vector and main request flag
`default_nettype none
// Behaviour
// RULE1 - per-source latch, set by event, write-one clears
// RULE2 - latch AND enable, all ORed to one request
// RULE3 - five-bit index, zero highest, 31 lowest
// RULE4 - control and bus event codes 00 to 18
// RULE5 - endpoint event codes 20 to 40
// RULE6 - ping-nak, error-limit, iso error codes
// RULE7 - vector shows highest pending enabled source
// RULE8 - autovector replaces fetched byte at 0x0045
// RULE9 - any gated request sets main flag
// RULE10 - main request forwarded only while enabled
// RULE11 - main flag cleared only by firmware
// RULE12 - clearing a latch re-pulses remaining requests
// RULE13 - firmware clears main flag before latch
// RULE14 - setup token request on setup decode
// RULE15 - setup data request after eight clean bytes
// RULE16 - firmware reads eight setup bytes
// RULE17 - frame number stored, then sof request
// RULE18 - host sets sof rate, 1ms or 125us
// RULE19 - full-speed variant drops high-speed sources
// RULE20 - vector is index shifted left by two
// RULE21 - substitution only while autovector enabled
// RULE22 - reserved never set, latches held until cleared
module uirq_dev_end
    import uirq_pkg::*;
#(
    parameter bit FULL_SPEED_ONLY = 1'b0
)
(
    input wire logic core_clk_in,
    input wire logic rstn_in,
    uirq_if.dev bus_if,
    input wire logic [31:0] sie_event_in,
    input wire logic sie_setup_tok_in,
    input wire logic sie_setup_vld_in,
    input wire logic [7:0] sie_setup_byte_in,
    input wire logic sie_setup_err_in,
    input wire logic sie_setup_end_in,
    input wire logic sie_sof_in,
    input wire logic [10:0] sie_frame_in,
    output logic usb_irq_out,
    output logic [7:0] usb_vector_byte_out
);
    // ***********************************************
    // state
    // ***********************************************
    logic [31:0] latch_r;
    logic [31:0] latch_nxt;
    logic any_r;
    logic clr_hit_r;
    logic main_flag_r;
    logic main_flag_nxt;
    logic cpu_irq_r;
    logic [7:0] vector_r;
    logic [7:0] fetch_data_r;
    logic [7:0] setup_mem_r [0:UIRQ_SETUP_BYTES-1];
    logic [3:0] setup_cnt_r;
    logic setup_bad_r;
    logic setup_done_r;
    logic sof_pend_r;
    logic [10:0] frame_r;

    // ***********************************************
    // request latches
    // ***********************************************
    // sources that may ever set in this variant
    wire [31:0] variant_mask = FULL_SPEED_ONLY ? ~UIRQ_HS_ONLY_MASK : 32'hFFFF_FFFF; // RULE19
    wire [31:0] legal_mask = variant_mask & ~UIRQ_RSVD_MASK; // RULE22
    wire [31:0] int_set;
    wire [31:0] set_vec;
    wire [31:0] clr_vec;

    // internally generated sources at fixed indices
    assign int_set[UIRQ_IDX_SETUP_DATA] = setup_done_r; // RULE15
    assign int_set[UIRQ_IDX_SOF] = sof_pend_r; // RULE17
    assign int_set[UIRQ_IDX_SETUP_TOK] = sie_setup_tok_in; // RULE14
    assign int_set[31:3] = 29'h0000_0000;

    // index position gives the vector code per table order
    assign set_vec = legal_mask & ((sie_event_in & ~UIRQ_INTERNAL_MASK) | int_set); // RULE4 RULE5 RULE6
    assign clr_vec = bus_if.clr_we ? bus_if.clr_mask : 32'h0000_0000;
    assign latch_nxt = (latch_r & ~clr_vec) | set_vec; // RULE1 RULE22

    // ***********************************************
    // gating and prioritizing
    // ***********************************************
    wire [31:0] gated = latch_r & bus_if.ie; // RULE2
    wire any_req = |gated; // RULE2 RULE9
    logic [4:0] win_idx;

    // lowest set position wins, index zero highest
    always_comb begin
        win_idx = 5'h1F;
        for (int i = UIRQ_NSRC - 1; i >= 0; i--) begin
            if (gated[i]) begin
                win_idx = 5'(i); // RULE3 RULE7
            end
        end
    end

    wire [7:0] vector_nxt = {1'b0, win_idx, 2'b00}; // RULE20
    // a write that cleared an enabled pending latch
    wire clr_hit = bus_if.clr_we && (|(bus_if.clr_mask & gated));
    // new pulse on first request or after a latch clear
    wire req_pulse = any_req && (!any_r || clr_hit_r); // RULE12

    // ***********************************************
    // main shared request flag
    // ***********************************************
    // set beats a simultaneous firmware clear
    assign main_flag_nxt = req_pulse ? 1'b1 : (bus_if.main_clr ? 1'b0 : main_flag_r); // RULE9 RULE11

    // ***********************************************
    // fetch substitution
    // ***********************************************
    wire av_hit = bus_if.av_en && (bus_if.fetch_addr == UIRQ_AUTOVEC_ADDR); // RULE21
    wire [7:0] fetch_nxt = av_hit ? vector_r : bus_if.fetch_byte; // RULE8

    // latches, flag and vector registers
    always_ff @(posedge core_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            latch_r <= 32'h0000_0000;
            any_r <= 1'b0;
            clr_hit_r <= 1'b0;
            main_flag_r <= 1'b0;
            cpu_irq_r <= 1'b0;
            vector_r <= 8'h00;
            fetch_data_r <= 8'h00;
        end else begin
            latch_r <= latch_nxt;
            any_r <= any_req;
            clr_hit_r <= clr_hit;
            main_flag_r <= main_flag_nxt;
            cpu_irq_r <= main_flag_r && bus_if.eie_usb; // RULE10
            vector_r <= vector_nxt; // RULE7
            fetch_data_r <= fetch_nxt;
        end
    end

    // ***********************************************
    // setup packet capture
    // ***********************************************
    wire setup_store = sie_setup_vld_in && (setup_cnt_r < UIRQ_SETUP_CNT_FULL);
    wire setup_over = sie_setup_vld_in && (setup_cnt_r == UIRQ_SETUP_CNT_FULL);
    wire setup_ok = sie_setup_end_in && !setup_bad_r && !sie_setup_err_in
                    && (setup_cnt_r == UIRQ_SETUP_CNT_FULL);

    // byte counter and error tracking for one setup stage
    always_ff @(posedge core_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            setup_cnt_r <= 4'h0;
            setup_bad_r <= 1'b0;
            setup_done_r <= 1'b0;
        end else begin
            setup_done_r <= setup_ok; // RULE15
            if (sie_setup_tok_in) begin
                setup_cnt_r <= 4'h0;
                setup_bad_r <= 1'b0;
            end else begin
                if (setup_store) begin
                    setup_cnt_r <= setup_cnt_r + 4'h1;
                end
                if (setup_over || sie_setup_err_in) begin
                    setup_bad_r <= 1'b1;
                end
            end
        end
    end

    // one storage byte per setup position
    genvar g;
    generate
        for (g = 0; g < UIRQ_SETUP_BYTES; g++) begin : g_setup
            always_ff @(posedge core_clk_in or negedge rstn_in) begin
                if (!rstn_in) begin
                    setup_mem_r[g] <= 8'h00;
                end else if (setup_store && (setup_cnt_r == 4'(g))) begin
                    setup_mem_r[g] <= sie_setup_byte_in;
                end
            end
            assign bus_if.setup_bytes[g*8 +: 8] = setup_mem_r[g];
        end
    endgenerate

    // ***********************************************
    // start of frame
    // ***********************************************
    // frame number lands one edge before the request sets
    always_ff @(posedge core_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            frame_r <= 11'h000;
            sof_pend_r <= 1'b0;
        end else begin
            sof_pend_r <= sie_sof_in; // RULE17
            if (sie_sof_in) begin
                frame_r <= sie_frame_in;
            end
        end
    end

    // ***********************************************
    // outputs
    // ***********************************************
    assign bus_if.irq_latch = latch_r;
    assign bus_if.vector_byte = vector_r;
    assign bus_if.main_flag = main_flag_r;
    assign bus_if.cpu_irq = cpu_irq_r;
    assign bus_if.fetch_data = fetch_data_r;
    assign bus_if.frame_number = frame_r;
    assign usb_irq_out = cpu_irq_r;
    assign usb_vector_byte_out = vector_r;
endmodule : uirq_dev_end
`default_nettype wire

// *** sim/uirq_properties.sv ***
// concurrent checks on the interface joining the two ends
`default_nettype none
module uirq_properties
    import uirq_pkg::*;
(
    input wire logic core_clk_in,
    input wire logic rstn_in,
    input wire logic [31:0] ie,
    input wire logic clr_we,
    input wire logic [31:0] clr_mask,
    input wire logic main_clr,
    input wire logic eie_usb,
    input wire logic av_en,
    input wire logic [15:0] fetch_addr,
    input wire logic [7:0] fetch_byte,
    input wire logic [31:0] irq_latch,
    input wire logic [7:0] vector_byte,
    input wire logic main_flag,
    input wire logic cpu_irq,
    input wire logic [7:0] fetch_data
);
    timeunit 1ns;
    timeprecision 100ps;
    // lowest pending index wins, nothing pending shows the last slot
    function automatic logic [7:0] exp_vec(input logic [31:0] g);
        logic [7:0] v;
        v = 8'h7C;
        for (int i = 31; i >= 0; i--) begin
            if (g[i]) begin
                v = {1'b0, i[4:0], 2'b00};
            end
        end
        return v;
    endfunction : exp_vec

    default clocking cb @(posedge core_clk_in);
    endclocking
    default disable iff (!rstn_in);

    // ****************
    // properties
    // ****************
    a_rsvd_never_set: assert property ((irq_latch & UIRQ_RSVD_MASK) == 32'h0)
        else $error("reserved latch set");
    a_latch_held: assert property ($past(rstn_in) |->
        ((($past(irq_latch) & ~irq_latch) & ~($past(clr_mask) & {32{$past(clr_we)}})) == 32'h0))
        else $error("latch dropped without clear");
    a_vec_winner: assert property ($past(rstn_in) |->
        vector_byte == exp_vec($past(irq_latch & ie)))
        else $error("vector not the highest pending source");
    a_irq_gated: assert property ($past(rstn_in) |-> cpu_irq == $past(main_flag & eie_usb))
        else $error("request not gated by enable");
    a_flag_fw_clear: assert property ($fell(main_flag) |-> $past(main_clr))
        else $error("main flag cleared on its own");
    a_flag_on_req: assert property ($rose(|(irq_latch & ie)) |=> main_flag)
        else $error("main flag missed a request");
    a_repulse_next: assert property (clr_we && |(irq_latch & ie & clr_mask) &&
        |(irq_latch & ie & ~clr_mask) |-> ##[1:3] main_flag)
        else $error("no new pulse after clear");
    a_fetch_subst: assert property ($past(rstn_in) |-> fetch_data ==
        ($past(av_en && fetch_addr == UIRQ_AUTOVEC_ADDR) ? $past(vector_byte) : $past(fetch_byte)))
        else $error("fetched byte wrong");
endmodule : uirq_properties
`default_nettype wire

// *** sim/tb.sv ***
// testbench joining the device and firmware ends
`default_nettype none
module tb
    import uirq_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic [31:0] ev = 32'h0;
    logic [31:0] ev2 = 32'h0;
    logic [31:0] uie = 32'h0;
    logic tok = 1'b0, vld = 1'b0, serr = 1'b0, send = 1'b0, sof = 1'b0;
    logic ext_irq_enable_reg = 1'b0, av = 1'b0, svc = 1'b0;
    logic [7:0] sbyte = 8'h00, fbyte = 8'h00;
    logic [15:0] faddr = 16'h0000;
    logic [10:0] frame = 11'h000;
    logic usb_irq, uirq_o, busy;
    logic [7:0] vec, fdata;
    logic [4:0] sidx;
    logic [63:0] setup;
    int miscompares = 0;
    int cmp_count = 0;
    uirq_if bus_if ();
    uirq_if bad_if ();

    // main pair, a full-speed device end on a misbehaving bus, and the checker
    uirq_dev_end uirq_dev_end_inst (.core_clk_in(clk), .rstn_in(rstn), .bus_if(bus_if),
        .sie_event_in(ev), .sie_setup_tok_in(tok), .sie_setup_vld_in(vld),
        .sie_setup_byte_in(sbyte), .sie_setup_err_in(serr), .sie_setup_end_in(send),
        .sie_sof_in(sof), .sie_frame_in(frame), .usb_irq_out(usb_irq), .usb_vector_byte_out(vec));
    uirq_dev_end #(.FULL_SPEED_ONLY(1'b1)) uirq_dev_end_inst2 (.core_clk_in(clk),
        .rstn_in(rstn), .bus_if(bad_if), .sie_event_in(ev2), .sie_setup_tok_in(tok),
        .sie_setup_vld_in(vld), .sie_setup_byte_in(sbyte), .sie_setup_err_in(serr),
        .sie_setup_end_in(send), .sie_sof_in(sof), .sie_frame_in(frame), .usb_irq_out(),
        .usb_vector_byte_out());
    uirq_fw_end uirq_fw_end_inst (.core_clk_in(clk), .rstn_in(rstn), .bus_if(bus_if),
        .user_ie_in(uie), .user_eie_in(ext_irq_enable_reg), .user_av_in(av), .user_svc_in(svc),
        .user_fetch_addr_in(faddr), .user_fetch_byte_in(fbyte), .user_irq_out(uirq_o),
        .user_busy_out(busy), .user_svc_idx_out(sidx), .user_setup_out(setup),
        .user_fetch_data_out(fdata));
    uirq_properties uirq_properties_inst (.core_clk_in(clk), .rstn_in(rstn), .ie(bus_if.ie),
        .clr_we(bus_if.clr_we), .clr_mask(bus_if.clr_mask), .main_clr(bus_if.main_clr),
        .eie_usb(bus_if.eie_usb), .av_en(bus_if.av_en), .fetch_addr(bus_if.fetch_addr),
        .fetch_byte(bus_if.fetch_byte), .irq_latch(bus_if.irq_latch),
        .vector_byte(bus_if.vector_byte), .main_flag(bus_if.main_flag),
        .cpu_irq(bus_if.cpu_irq), .fetch_data(bus_if.fetch_data));

    // 20 MHz clock
    always #25 clk = ~clk;

    // ****************
    // access tasks
    // ****************
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : tick

    task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
        cmp_count++;
        if (got !== exp) begin
            miscompares++;
            $display("[FAIL] %s expected %0h seen %0h", what, exp, got);
        end
    endtask : chk

    task automatic fire(input logic [31:0] m);
        ev = m;
        tick(1);
        ev = 32'h0;
        tick(3);
    endtask : fire

    // one firmware service pass, bounded wait for its end
    task automatic serve();
        svc = 1'b1;
        tick(1);
        svc = 1'b0;
        tick(1);
        for (int k = 0; busy === 1'b1; k++) begin
            if (k > 20) begin
                miscompares++;
                final_report();
            end
            tick(1);
        end
        tick(4);
    endtask : serve

    // token, n data bytes, optional error, end of stage
    task automatic setup_pkt(input int n, input logic bad);
        tok = 1'b1;
        tick(1);
        tok = 1'b0;
        for (int k = 0; k < n; k++) begin
            vld = 1'b1;
            sbyte = 8'(8'h10 + k);
            tick(1);
        end
        vld = 1'b0;
        serr = bad;
        tick(1);
        serr = 1'b0;
        send = 1'b1;
        tick(1);
        send = 1'b0;
        tick(3);
    endtask : setup_pkt

    task automatic final_report();
        $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : final_report

    // main sequence
    initial begin
        logic rs;
        {bad_if.ie, bad_if.eie_usb, bad_if.clr_we, bad_if.main_clr, bad_if.av_en} =
            {32'hFFFF_FFFF, 4'h8};
        {bad_if.clr_mask, bad_if.fetch_addr, bad_if.fetch_byte} = {32'h8, 24'h0};
        repeat (20) @(posedge clk);
        #1;
        rstn = 1'b1;
        chk("latch_rst", 64'h0, bus_if.irq_latch);
        uie = 32'hFFFF_FFFF;
        ext_irq_enable_reg = 1'b1;
        tick(2);
        for (int i = 3; i < 32; i++) begin
            fire(32'h1 << i);
            rs = UIRQ_RSVD_MASK[i];
            chk("vector", rs ? 64'h7C : 64'(i * 4), vec);
            chk("usb_irq", !rs, usb_irq);
            chk("user_irq", !rs, uirq_o);
            if (!rs) begin
                serve();
                chk("svc_idx", 64'(i), sidx);
                chk("latch_clr", 64'h0, bus_if.irq_latch);
            end
        end
        $display("test codes done");
        fire(32'h4000_0200);
        chk("vec_both", 64'h24, vec);
        serve();
        chk("first_idx", 64'h9, sidx);
        chk("vec_next", 64'h78, vec);
        chk("repulse", 64'h1, bus_if.main_flag);
        serve();
        chk("second_idx", 64'h1E, sidx);
        $display("test priority done");
        uie = 32'h0;
        ext_irq_enable_reg = 1'b0;
        tick(2);
        fire(32'h1000);
        chk("held", 64'h1, bus_if.irq_latch[12]);
        chk("masked_flag", 64'h0, bus_if.main_flag);
        uie = 32'hFFFF_FFFF;
        tick(4);
        chk("flag_on", 64'h1, bus_if.main_flag);
        chk("irq_off", 64'h0, uirq_o);
        ext_irq_enable_reg = 1'b1;
        tick(4);
        chk("irq_on", 64'h1, uirq_o);
        serve();
        $display("test enables done");
        for (int c = 0; c < 4; c++) begin
            setup_pkt(c == 1 ? 7 : (c == 2 ? 9 : 8), c == 3);
            chk("setup_ready", c == 0, bus_if.irq_latch[0]);
            chk("setup_tok", 64'h1, bus_if.irq_latch[2]);
            if (c == 0) begin
                serve();
                chk("setup_bytes", 64'h1716_1514_1312_1110, setup);
            end
            serve();
        end
        $display("test setup done");
        frame = 11'h7A5;
        sof = 1'b1;
        tick(1);
        {sof, frame} = 12'h000;
        tick(3);
        chk("frame", 64'h7A5, bus_if.frame_number);
        chk("vec_sof", 64'h4, vec);
        serve();
        $display("test frame done");
        fire(32'h2000);
        fbyte = 8'hA5;
        for (int a = 0; a < 3; a++) begin
            av = (a != 2);
            faddr = (a == 1) ? 16'h0044 : UIRQ_AUTOVEC_ADDR;
            tick(4);
            chk("fetch", a == 0 ? 64'h34 : 64'hA5, fdata);
        end
        serve();
        $display("test autovector done");
        // setup and frame stimulus also reached this end: drop those latches first
        bad_if.clr_mask = 32'h0000_0007;
        bad_if.clr_we = 1'b1;
        tick(1);
        bad_if.clr_we = 1'b0;
        bad_if.clr_mask = 32'h0000_0008;
        tick(1);
        ev2 = 32'h00FC_0020;
        tick(1);
        ev2 = 32'h0000_0208;
        tick(1);
        ev2 = 32'h0;
        tick(3);
        chk("fs_latches", 64'h208, bad_if.irq_latch);
        bad_if.clr_we = 1'b1;
        tick(1);
        bad_if.clr_we = 1'b0;
        tick(3);
        bad_if.main_clr = 1'b1;
        tick(1);
        bad_if.main_clr = 1'b0;
        tick(4);
        chk("lost_flag", 64'h0, bad_if.main_flag);
        chk("still_pend", 64'h200, bad_if.irq_latch);
        $display("test misorder done");
        final_report();
    end
endmodule : tb
`default_nettype wire
